// ==== hdl/clkdiv_defs.svh ====
/*
  Register indices, field positions, reset values and divider counts for
  the audio interface clock divider.
  Assumes it is included by bare name from the top design file and from the bench.
*/
`ifndef CLKDIV_DEFS_SVH
`define CLKDIV_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_POWER_MANAGEMENT_FOUR 8'h0b
`define IDX_CLOCK_CONTROL_ONE 8'h28
`define IDX_CLOCK_CONTROL_TWO 8'h29
`define IDX_PLAYBACK_FRAME_RATE 8'h35
`define IDX_RECORD_FRAME_RATE 8'h46
`define IDX_BIT_CLOCK_CONTROL 8'h73
`define IDX_PIN_FUNCTION 8'h80

// Field positions
`define POS_PM4_SLOW_EN 8
`define POS_CC1_SLOW_EN 15
`define POS_CC1_SLOW_RATE 14
`define POS_CC1_BCLK_DIV_HI 7
`define POS_CC1_BCLK_DIV_LO 4
`define POS_CC1_AUX_DIV_HI 2
`define POS_CC2_FRAME_SEL 15
`define POS_RATE_GEN_EN 11
`define POS_RATE_LEN_HI 10
`define POS_BCC_MASTER 14
`define POS_PIN_AUX_FUNC 0
`define POS_PIN_REC_ALT 1

// Reset values
`define RST_FRAME_LEN 11'h040
`define RST_BCLK_DIV 4'h0
`define RST_AUX_DIV 3'h0

// Slow clock division ratios, as powers of two
`define SLOW_DIV_SLOW_LOG2 21
`define SLOW_DIV_FAST_LOG2 19

`endif

// ==== hdl/clkdiv_pkg.sv ====
/*
  Types shared by the clock divider modules.
  Assumes nothing of its surroundings.
*/
package clkdiv_pkg;
  // Length of one output period in system clock cycles
  typedef logic [5:0] period_t;
  // Bit clock source
  typedef enum logic [1:0] {
    BCLK_SLAVE = 2'b01,
    BCLK_MASTER = 2'b10
  } bclk_mode_t;
endpackage : clkdiv_pkg

// ==== hdl/frac_clk_div.sv ====
/*
  Divides the system clock by an integer or half-integer ratio. The
  period alternates between two lengths so the average ratio is exact.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module frac_clk_div (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic run_i,
  input wire clkdiv_pkg::period_t period_a_i,
  input wire clkdiv_pkg::period_t period_b_i,
  // Outputs
  output logic level_o,
  output logic tick_o
);
  clkdiv_pkg::period_t cnt_r;
  clkdiv_pkg::period_t cnt_nxt;
  clkdiv_pkg::period_t per_a_r;
  clkdiv_pkg::period_t per_a_nxt;
  clkdiv_pkg::period_t per_b_r;
  clkdiv_pkg::period_t per_b_nxt;
  clkdiv_pkg::period_t per_cur;
  clkdiv_pkg::period_t per_nxt;
  clkdiv_pkg::period_t high_nxt;
  logic phase_r;
  logic phase_nxt;
  logic run_r;
  logic wrap;
  logic load;

  // Ratio is taken only at a period start, so a code change never
  // stretches or clips the period in flight; the first cycle of a run
  // starts a period at once
  assign per_cur = phase_r ? per_b_r : per_a_r;
  assign wrap = run_r && (cnt_r >= per_cur - 6'h01);
  assign load = !run_r || wrap;
  assign per_a_nxt = load ? period_a_i : per_a_r;
  assign per_b_nxt = load ? period_b_i : per_b_r;

  // Period alternation: unequal lengths average to the half ratio
  assign cnt_nxt = (!run_i || load) ? 6'h00 : cnt_r + 6'h01;
  assign phase_nxt = run_i && (wrap ? ~phase_r : phase_r);
  assign per_nxt = phase_nxt ? per_b_nxt : per_a_nxt;
  assign high_nxt = (per_nxt + 6'h01) >> 1;

  // Counter, latched ratio and registered output level
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_r <= 6'h00;
      phase_r <= 1'b0;
      run_r <= 1'b0;
      per_a_r <= 6'h00;
      per_b_r <= 6'h00;
      level_o <= 1'b0;
      tick_o <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      phase_r <= phase_nxt;
      run_r <= run_i;
      per_a_r <= per_a_nxt;
      per_b_r <= per_b_nxt;
      level_o <= run_i && (cnt_nxt < high_nxt);
      tick_o <= run_i && (cnt_nxt == 6'h00);
    end
  end
endmodule : frac_clk_div

// ==== hdl/frame_clk_gen.sv ====
/*
  Frame clock generator: toggles its output after a programmed number of
  bit clock ticks, so one frame spans twice that count.
  Assumes bit ticks are one-cycle pulses on the system clock.
*/
`timescale 1ns/1ps
module frame_clk_gen #(
  parameter int LEN_W = 11
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic enable_i,
  input wire logic bit_tick_i,
  input wire logic [LEN_W-1:0] length_i,
  // Output
  output logic frame_o
);
  logic [LEN_W-1:0] cnt_r;
  logic last;

  assign last = (cnt_r >= length_i - 1'b1);

  // Phase counter, held clear while disabled
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !enable_i) begin
      cnt_r <= '0;
      frame_o <= 1'b0;
    end else if (bit_tick_i) begin
      cnt_r <= last ? '0 : cnt_r + 1'b1;
      frame_o <= last ? ~frame_o : frame_o;
    end
  end
endmodule : frame_clk_gen

// ==== hdl/audio_clk_divider.sv ====
/*
  Audio interface clock divider: bit clock, two frame clocks, shared
  frame pin selection, auxiliary output clock and slow timeout clock,
  with an APB register slave.
  Assumes one 40 MHz clock, synchronous active-low reset and pins that
  are synchronous to the clock.
*/
//
// Behaviour
// - Bit clock divider codes select listed ratios
// - Master select bit chooses bit clock drive
// - Master mode divides system clock for bit clock
// - Frame clocks divide the bit clock
// - Frame length field counts bit clocks per phase
// - Record frame generation enable bit
// - Playback frame generation enable in master mode
// - Select bit routes frame clock to pin
// - Separate record frame pin only when configured
// - Aux clock output only when pin configured
// - Aux divider codes select listed ratios
// - Slow clock enable starts and stops it
// - Rate bit picks two to 21 or 19
// - Slow enable aliased at two registers
`timescale 1ns/1ps
`include "clkdiv_defs.svh"
module audio_clk_divider #(
  parameter int LEN_W = 11,
  parameter int SLOW_DIV_SLOW = 2 ** `SLOW_DIV_SLOW_LOG2,
  parameter int SLOW_DIV_FAST = 2 ** `SLOW_DIV_FAST_LOG2
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Bit clock pin
  input wire logic BIT_CLK_I,
  output logic BIT_CLK_O,
  output logic BIT_CLK_OE_O,
  // Shared frame pin
  input wire logic FRAME_CLK_I,
  output logic FRAME_CLK_O,
  output logic FRAME_CLK_OE_O,
  // Separate record frame pin
  output logic REC_FRAME_ALT_O,
  output logic REC_FRAME_ALT_OE_O,
  // Auxiliary output clock pin
  output logic AUX_CLK_O,
  output logic AUX_CLK_OE_O,
  // Timing to the rest of the interface
  output logic BIT_TICK_O,
  output logic FRAME_LEVEL_O,
  output logic SLOW_TICK_O
);
  // Register storage; each field is a flop of its own, so the slow
  // clock enable seen at two register locations is still one bit
  logic [3:0] bclk_div_r;
  logic [2:0] aux_div_r;
  logic slow_en_r;
  logic slow_rate_r;
  logic frame_sel_r;
  logic play_en_r;
  logic rec_en_r;
  logic [LEN_W-1:0] play_len_r;
  logic [LEN_W-1:0] rec_len_r;
  logic master_r;
  logic aux_func_r;
  logic rec_alt_r;
  logic [31:0] prdata_nxt;
  logic bclk_in_r;
  logic slow_tick_r;
  logic [21:0] slow_cnt_r;

  // Bit clock divider decode into alternating period lengths. The upper
  // six bits give the first period, the lower six the second; the half
  // ratios pair a short and a long period, other codes two equal ones.
  // Codes above the last listed ratio all fall to the slowest one.
  function automatic logic [11:0] bclk_periods(input logic [3:0] code);
    case (code)
      4'h0: bclk_periods = {6'd1, 6'd1};
      4'h1: bclk_periods = {6'd1, 6'd2};
      4'h2: bclk_periods = {6'd2, 6'd2};
      4'h3: bclk_periods = {6'd3, 6'd3};
      4'h4: bclk_periods = {6'd4, 6'd4};
      4'h5: bclk_periods = {6'd5, 6'd6};
      4'h6: bclk_periods = {6'd6, 6'd6};
      4'h7: bclk_periods = {6'd8, 6'd8};
      4'h8: bclk_periods = {6'd11, 6'd11};
      4'h9: bclk_periods = {6'd12, 6'd12};
      4'ha: bclk_periods = {6'd16, 6'd16};
      4'hb: bclk_periods = {6'd22, 6'd22};
      4'hc: bclk_periods = {6'd24, 6'd24};
      default: bclk_periods = {6'd32, 6'd32};
    endcase
  endfunction : bclk_periods

  // Aux divider decode; reserved codes stop the clock. A zero length
  // holds the divider idle, so the pin stays low instead of running at
  // a rate nobody asked for.
  function automatic logic [11:0] aux_periods(input logic [2:0] code);
    case (code)
      3'h0: aux_periods = {6'd1, 6'd1};
      3'h1: aux_periods = {6'd2, 6'd2};
      3'h2: aux_periods = {6'd3, 6'd3};
      3'h3: aux_periods = {6'd4, 6'd4};
      3'h4: aux_periods = {6'd5, 6'd6};
      3'h5: aux_periods = {6'd6, 6'd6};
      default: aux_periods = {6'd0, 6'd0};
    endcase
  endfunction : aux_periods

  // Byte-lane merge of a 16-bit register image. Lanes 2 and 3 carry
  // nothing: every register is 16 bits wide, so upper strobes and data
  // are ignored.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] strb);
    merge16 = {strb[1] ? wd[15:8] : old[15:8],
               strb[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // APB address decode. An address above the index range, or one that
  // is not word aligned, misses every register; such an access is
  // answered with an error and changes nothing.
  // The index is the byte address divided by four.
  wire [7:0] idx = PADDR_I[9:2];
  wire in_range = (PADDR_I[31:10] == 22'h0) && (PADDR_I[1:0] == 2'b00);
  wire hit_pm4 = in_range && (idx == `IDX_POWER_MANAGEMENT_FOUR);
  wire hit_cc1 = in_range && (idx == `IDX_CLOCK_CONTROL_ONE);
  wire hit_cc2 = in_range && (idx == `IDX_CLOCK_CONTROL_TWO);
  wire hit_play = in_range && (idx == `IDX_PLAYBACK_FRAME_RATE);
  wire hit_rec = in_range && (idx == `IDX_RECORD_FRAME_RATE);
  wire hit_bcc = in_range && (idx == `IDX_BIT_CLOCK_CONTROL);
  wire hit_pin = in_range && (idx == `IDX_PIN_FUNCTION);
  wire mapped = hit_pm4 | hit_cc1 | hit_cc2 | hit_play | hit_rec |
                hit_bcc | hit_pin;
  wire wr_en = PSEL_I && PENABLE_I && PWRITE_I && mapped;

  // Register images as seen by software. Unused bits read as zero, and
  // both slow clock enable positions show the same flop.
  wire [15:0] img_pm4 = 16'({slow_en_r, 8'h00});
  wire [15:0] img_cc1 = {slow_en_r, slow_rate_r, 6'h00, bclk_div_r,
                         1'b0, aux_div_r};
  wire [15:0] img_cc2 = {frame_sel_r, 15'h0000};
  wire [15:0] img_play = 16'({play_en_r, play_len_r});
  wire [15:0] img_rec = 16'({rec_en_r, rec_len_r});
  wire [15:0] img_bcc = {1'b0, master_r, 14'h0000};
  wire [15:0] img_pin = {14'h0000, rec_alt_r, aux_func_r};

  // Write values after byte-lane merge; a lane whose strobe is low
  // keeps the value the register already holds
  wire [15:0] w_pm4 = merge16(img_pm4, PWDATA_I, PSTRB_I);
  wire [15:0] w_cc1 = merge16(img_cc1, PWDATA_I, PSTRB_I);
  wire [15:0] w_cc2 = merge16(img_cc2, PWDATA_I, PSTRB_I);
  wire [15:0] w_play = merge16(img_play, PWDATA_I, PSTRB_I);
  wire [15:0] w_rec = merge16(img_rec, PWDATA_I, PSTRB_I);
  wire [15:0] w_bcc = merge16(img_bcc, PWDATA_I, PSTRB_I);
  wire [15:0] w_pin = merge16(img_pin, PWDATA_I, PSTRB_I);

  // Read data select, captured in the setup cycle. Ready is tied high:
  // the slave never inserts wait states, so the access phase is always
  // the answer cycle and read data must already stand by then.
  assign prdata_nxt = hit_pm4 ? {16'h0000, img_pm4} :
                      hit_cc1 ? {16'h0000, img_cc1} :
                      hit_cc2 ? {16'h0000, img_cc2} :
                      hit_play ? {16'h0000, img_play} :
                      hit_rec ? {16'h0000, img_rec} :
                      hit_bcc ? {16'h0000, img_bcc} :
                      hit_pin ? {16'h0000, img_pin} : 32'h0000_0000;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;

  // Read data register; holds its value until the next read setup
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      PRDATA_O <= prdata_nxt;
    end
  end

  // Clock control registers. A write to either alias updates the single
  // enable flop; one access can never hit both locations at once.
  // New values reach the dividers in the cycle after the write edge.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      bclk_div_r <= `RST_BCLK_DIV;
      aux_div_r <= `RST_AUX_DIV;
      slow_en_r <= 1'b0;
      slow_rate_r <= 1'b0;
      frame_sel_r <= 1'b0;
      master_r <= 1'b0;
    end else if (wr_en) begin
      if (hit_pm4) slow_en_r <= w_pm4[`POS_PM4_SLOW_EN];
      if (hit_cc1) begin
        slow_en_r <= w_cc1[`POS_CC1_SLOW_EN];
        slow_rate_r <= w_cc1[`POS_CC1_SLOW_RATE];
        bclk_div_r <= w_cc1[`POS_CC1_BCLK_DIV_HI:`POS_CC1_BCLK_DIV_LO];
        aux_div_r <= w_cc1[`POS_CC1_AUX_DIV_HI:0];
      end
      if (hit_cc2) frame_sel_r <= w_cc2[`POS_CC2_FRAME_SEL];
      if (hit_bcc) master_r <= w_bcc[`POS_BCC_MASTER];
    end
  end

  // Frame rate and pin function registers. Lengths below eight are not
  // refused here; software is expected never to program them.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      play_en_r <= 1'b0;
      rec_en_r <= 1'b0;
      play_len_r <= LEN_W'(`RST_FRAME_LEN);
      rec_len_r <= LEN_W'(`RST_FRAME_LEN);
      aux_func_r <= 1'b0;
      rec_alt_r <= 1'b0;
    end else if (wr_en) begin
      if (hit_play) begin
        play_en_r <= w_play[`POS_RATE_GEN_EN];
        play_len_r <= w_play[LEN_W-1:0];
      end
      if (hit_rec) begin
        rec_en_r <= w_rec[`POS_RATE_GEN_EN];
        rec_len_r <= w_rec[LEN_W-1:0];
      end
      if (hit_pin) begin
        aux_func_r <= w_pin[`POS_PIN_AUX_FUNC];
        rec_alt_r <= w_pin[`POS_PIN_REC_ALT];
      end
    end
  end

  // Bit clock generation in master mode. In slave mode the divider is
  // held at rest with its level low, and it starts a fresh period on
  // the first cycle after master mode is chosen.
  clkdiv_pkg::bclk_mode_t mode;
  wire [11:0] bclk_per = bclk_periods(bclk_div_r);
  wire [11:0] aux_per = aux_periods(aux_div_r);
  wire bclk_level;
  wire bclk_tick_int;
  assign mode = master_r ? clkdiv_pkg::BCLK_MASTER
                         : clkdiv_pkg::BCLK_SLAVE;
  frac_clk_div u_bclk_div (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .run_i(mode == clkdiv_pkg::BCLK_MASTER),
    .period_a_i(bclk_per[11:6]),
    .period_b_i(bclk_per[5:0]),
    .level_o(bclk_level),
    .tick_o(bclk_tick_int)
  );

  // Slave bit clock edge detect on the input pin. The sample flop
  // resets low, the idle level of the pin, so no false edge follows
  // reset.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      bclk_in_r <= 1'b0;
    end else begin
      bclk_in_r <= BIT_CLK_I;
    end
  end

  // Bit clock pin and tick to the serial logic. In slave mode the tick
  // comes straight from the pin and its previous sample; in master mode
  // it comes from the divider, in the cycle the level rises.
  wire slave_tick = BIT_CLK_I && !bclk_in_r;
  assign BIT_CLK_O = bclk_level;
  assign BIT_CLK_OE_O = (mode == clkdiv_pkg::BCLK_MASTER);
  assign BIT_TICK_O = (mode == clkdiv_pkg::BCLK_MASTER) ? bclk_tick_int
                                                         : slave_tick;

  // Frame clock generators, driven by the internal bit tick. Both rest
  // in slave mode, as the host then drives the frame pins itself.
  wire rec_frame;
  wire play_frame;
  frame_clk_gen #(.LEN_W(LEN_W)) u_rec_frame (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .enable_i(rec_en_r && master_r),
    .bit_tick_i(bclk_tick_int),
    .length_i(rec_len_r),
    .frame_o(rec_frame)
  );
  frame_clk_gen #(.LEN_W(LEN_W)) u_play_frame (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .enable_i(play_en_r && master_r),
    .bit_tick_i(bclk_tick_int),
    .length_i(play_len_r),
    .frame_o(play_frame)
  );

  // Shared frame pin: source select in master, input in slave. The pin
  // is driven only while the selected generator runs; otherwise the
  // level seen on the pin is passed on to the serial logic.
  wire sel_en = frame_sel_r ? rec_en_r : play_en_r;
  assign FRAME_CLK_O = frame_sel_r ? rec_frame : play_frame;
  assign FRAME_CLK_OE_O = master_r && sel_en;
  assign FRAME_LEVEL_O = FRAME_CLK_OE_O ? FRAME_CLK_O : FRAME_CLK_I;
  assign REC_FRAME_ALT_O = rec_frame;
  assign REC_FRAME_ALT_OE_O = rec_alt_r && master_r && rec_en_r;

  // Auxiliary output clock, driven only when the pin takes that function.
  // The divider runs only while the function is selected, so an unused
  // pin costs no toggling.
  wire aux_run = aux_func_r && (aux_per != 12'h000);
  wire aux_level;
  frac_clk_div u_aux_div (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .run_i(aux_run),
    .period_a_i(aux_per[11:6]),
    .period_b_i(aux_per[5:0]),
    .level_o(aux_level),
    .tick_o()
  );
  assign AUX_CLK_O = aux_level;
  assign AUX_CLK_OE_O = aux_func_r;

  // Slow clock: one tick per selected number of system clocks. The
  // counter is cleared while the enable is off, so every start gives a
  // full first interval. A rate change acts at once; a count already
  // past the new end wraps on the next cycle.
  wire [21:0] slow_last = slow_rate_r ? 22'(SLOW_DIV_FAST - 1)
                                      : 22'(SLOW_DIV_SLOW - 1);
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I || !slow_en_r) begin
      slow_cnt_r <= 22'h000000;
      slow_tick_r <= 1'b0;
    end else begin
      slow_cnt_r <= (slow_cnt_r >= slow_last) ? 22'h000000
                                              : slow_cnt_r + 22'h000001;
      slow_tick_r <= (slow_cnt_r >= slow_last);
    end
  end
  assign SLOW_TICK_O = slow_tick_r;
endmodule : audio_clk_divider

// ==== dv/clkdiv_monitor.sv ====
/* Assertions on the clock divider pins and its APB slave.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module clkdiv_monitor (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // APB
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic [31:0] PADDR_I,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  // Pins and timing
  input wire logic BIT_CLK_I,
  input wire logic BIT_CLK_O,
  input wire logic BIT_CLK_OE_O,
  input wire logic FRAME_CLK_I,
  input wire logic FRAME_CLK_O,
  input wire logic FRAME_CLK_OE_O,
  input wire logic REC_FRAME_ALT_O,
  input wire logic REC_FRAME_ALT_OE_O,
  input wire logic BIT_TICK_O,
  input wire logic FRAME_LEVEL_O,
  input wire logic SLOW_TICK_O
);
  int lo_run_r;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Length of the current low run of the generated bit clock
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I || !BIT_CLK_OE_O || BIT_CLK_O) lo_run_r <= 0;
    else lo_run_r <= lo_run_r + 1;
  end
  a_ready_high: assert property (PREADY_O) else $error("ready low");
  a_misalign_err: assert property (PSEL_I && PENABLE_I &&
    PADDR_I[1:0] != 2'h0 |-> PSLVERR_O) else $error("no slave error");
  a_tick_on_rise: assert property (BIT_CLK_OE_O && $rose(BIT_CLK_O) |->
    BIT_TICK_O) else $error("no tick at bit rise");
  a_slave_tick: assert property (!BIT_CLK_OE_O && !$past(BIT_CLK_OE_O) |->
    BIT_TICK_O == (BIT_CLK_I && !$past(BIT_CLK_I)))
    else $error("slave tick wrong");
  a_level_follow: assert property (!FRAME_CLK_OE_O |->
    FRAME_LEVEL_O == FRAME_CLK_I) else $error("level not pin");
  a_level_drive: assert property (FRAME_CLK_OE_O |->
    FRAME_LEVEL_O == FRAME_CLK_O) else $error("level not driven");
  a_frame_master: assert property (FRAME_CLK_OE_O |-> BIT_CLK_OE_O)
    else $error("frame driven in slave");
  a_alt_master: assert property (REC_FRAME_ALT_OE_O |-> BIT_CLK_OE_O)
    else $error("alt frame driven in slave");
  a_slow_pulse: assert property (SLOW_TICK_O |=> !SLOW_TICK_O [*8])
    else $error("slow tick too long");
  a_bclk_low_run: assert property (lo_run_r <= 16)
    else $error("bit clock low too long");
  a_frame_on_tick: assert property ($changed(REC_FRAME_ALT_O) &&
    REC_FRAME_ALT_OE_O && $past(REC_FRAME_ALT_OE_O) |->
    BIT_TICK_O || $past(BIT_TICK_O)) else $error("frame off tick");
  c_slow: cover property ($rose(SLOW_TICK_O));
  c_alt: cover property (REC_FRAME_ALT_OE_O && $rose(REC_FRAME_ALT_O));
  c_err: cover property (PSLVERR_O);
  c_slave: cover property (!BIT_CLK_OE_O && BIT_TICK_O);
endmodule : clkdiv_monitor
bind audio_clk_divider clkdiv_monitor u_clkdiv_monitor (.CLK_I(CLK_I),
  .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PADDR_I(PADDR_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .BIT_CLK_I(BIT_CLK_I), .BIT_CLK_O(BIT_CLK_O), .BIT_CLK_OE_O(BIT_CLK_OE_O),
  .FRAME_CLK_I(FRAME_CLK_I), .FRAME_CLK_O(FRAME_CLK_O),
  .FRAME_CLK_OE_O(FRAME_CLK_OE_O), .REC_FRAME_ALT_O(REC_FRAME_ALT_O),
  .REC_FRAME_ALT_OE_O(REC_FRAME_ALT_OE_O), .BIT_TICK_O(BIT_TICK_O),
  .FRAME_LEVEL_O(FRAME_LEVEL_O), .SLOW_TICK_O(SLOW_TICK_O));

// ==== dv/host_serial_model.sv ====
/* Host side of the serial audio link in slave mode: bit and frame clock.
   Assumes its pins are sampled on the system clock. */
`timescale 1ns/1ps
module host_serial_model #(
  parameter int HALF = 3,
  parameter int LEN = 8
) (
  input wire logic clk_i,
  input wire logic run_i,
  output logic bit_clk_o,
  output logic frame_clk_o
);
  int cnt;
  int bits;
  initial begin
    bit_clk_o = 1'h0;
    frame_clk_o = 1'h0;
    cnt = 0;
    bits = 0;
  end
  // Bit clock rests low while run_i is low; frame flips every LEN bit rises
  always @(posedge clk_i) begin
    if (!run_i) begin
      bit_clk_o <= 1'h0;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      bit_clk_o <= !bit_clk_o;
      if (!bit_clk_o && bits == LEN - 1) begin
        bits <= 0;
        frame_clk_o <= !frame_clk_o;
      end else if (!bit_clk_o) bits <= bits + 1;
    end else cnt <= cnt + 1;
  end
endmodule : host_serial_model

// ==== dv/tb.sv ====
/* Self-checking bench: APB registers, clock periods, host in slave mode.
   Assumes the design, its monitor and the host model. */
`timescale 1ns/1ps
`include "clkdiv_defs.svh"
module tb;
  logic CLK_I, RST_N_I, PSEL_I, PENABLE_I, PWRITE_I, host_run;
  logic [31:0] PADDR_I, PWDATA_I, PRDATA_O;
  logic [3:0] PSTRB_I;
  logic PREADY_O, PSLVERR_O, BIT_CLK_O, BIT_CLK_OE_O, FRAME_CLK_O;
  logic FRAME_CLK_OE_O, REC_FRAME_ALT_O, REC_FRAME_ALT_OE_O, AUX_CLK_O;
  logic AUX_CLK_OE_O, BIT_TICK_O, FRAME_LEVEL_O, SLOW_TICK_O;
  logic host_bclk, host_frame;
  logic [17:0] rq[$];
  logic [17:0] e;
  logic [5:0] evs;
  int err_count = 0;
  int check_count = 0;
  int len;
  localparam logic [9:0] PM4 = {`IDX_POWER_MANAGEMENT_FOUR, 2'h0};
  localparam logic [9:0] CC1 = {`IDX_CLOCK_CONTROL_ONE, 2'h0};
  localparam logic [9:0] CC2 = {`IDX_CLOCK_CONTROL_TWO, 2'h0};
  localparam logic [9:0] PB = {`IDX_PLAYBACK_FRAME_RATE, 2'h0};
  localparam logic [9:0] REC = {`IDX_RECORD_FRAME_RATE, 2'h0};
  localparam logic [9:0] BCC = {`IDX_BIT_CLOCK_CONTROL, 2'h0};
  localparam logic [9:0] PIN = {`IDX_PIN_FUNCTION, 2'h0};
  localparam logic [9:0] REGS[7] = '{PM4, CC1, CC2, PB, REC, BCC, PIN};
  localparam logic [15:0] RSTV[7] = '{0, 0, 0, 16'h40, 16'h40, 0, 0};
  localparam int BPER[16] = '{2, 3, 4, 6, 8, 11, 12, 16, 22, 24, 32, 44,
                              48, 64, 64, 64};
  localparam int APER[6] = '{0, 4, 6, 8, 11, 12};
  // Shared pins resolve to whoever drives them
  wire bit_pin = BIT_CLK_OE_O ? BIT_CLK_O : host_bclk;
  wire frame_pin = FRAME_CLK_OE_O ? FRAME_CLK_O : host_frame;
  assign evs = {FRAME_LEVEL_O, SLOW_TICK_O, REC_FRAME_ALT_O, FRAME_CLK_O,
                AUX_CLK_O, BIT_TICK_O};
  audio_clk_divider #(.SLOW_DIV_SLOW(64), .SLOW_DIV_FAST(16))
    u_audio_clk_divider (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .BIT_CLK_I(bit_pin),
    .BIT_CLK_O(BIT_CLK_O), .BIT_CLK_OE_O(BIT_CLK_OE_O),
    .FRAME_CLK_I(frame_pin), .FRAME_CLK_O(FRAME_CLK_O),
    .FRAME_CLK_OE_O(FRAME_CLK_OE_O), .REC_FRAME_ALT_O(REC_FRAME_ALT_O),
    .REC_FRAME_ALT_OE_O(REC_FRAME_ALT_OE_O), .AUX_CLK_O(AUX_CLK_O),
    .AUX_CLK_OE_O(AUX_CLK_OE_O), .BIT_TICK_O(BIT_TICK_O),
    .FRAME_LEVEL_O(FRAME_LEVEL_O), .SLOW_TICK_O(SLOW_TICK_O));
  host_serial_model #(.HALF(3), .LEN(8)) u_host_serial_model (.clk_i(CLK_I),
    .run_i(host_run), .bit_clk_o(host_bclk), .frame_clk_o(host_frame));
  // 40 MHz clock
  initial begin
    CLK_I = 1'h0;
    forever #12.5 CLK_I = ~CLK_I;
  end
  // Compare each finished transfer with the oldest note
  always @(posedge CLK_I) begin
    if (PSEL_I && PENABLE_I && PREADY_O) begin
      e = rq.pop_front();
      check_count++;
      if (PSLVERR_O !== e[16] || (e[17] && PRDATA_O !== {16'h0, e[15:0]}))
      begin
        err_count++;
        $display("CHECK FAILED %0t apb at %h", $time, PADDR_I);
      end
    end
  end
  task automatic close_out();
    if (err_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic chk(input logic ok);
    check_count++;
    if (ok !== 1'h1) begin
      err_count++;
      $display("CHECK FAILED %0t pin value", $time);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [9:0] a,
                     input logic [15:0] d, input logic er);
    @(posedge CLK_I);
    rq.push_back({!w, er, d});
    PSEL_I <= 1'h1;
    PWRITE_I <= w;
    PADDR_I <= {22'h0, a};
    PWDATA_I <= {16'($urandom), d};
    PSTRB_I <= {2'($urandom), 2'h3};
    @(posedge CLK_I);
    PENABLE_I <= 1'h1;
    do @(posedge CLK_I); while (PREADY_O !== 1'h1);
    PSEL_I <= 1'h0;
    PENABLE_I <= 1'h0;
  endtask : apb
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    apb(1'h1, a, d, 1'h0);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [15:0] d);
    apb(1'h0, a, d, 1'h0);
  endtask : rd
  task automatic settle();
    repeat (2) @(posedge CLK_I);
    #1;
  endtask : settle
  // Span in cycles of n event intervals, skipping the first event
  task automatic meas(input int w, input int n, input int x);
    int c;
    int k;
    int t;
    logic p;
    c = 0;
    k = -2;
    p = 1'h1;
    for (t = 0; t < 4000 && k < n; t++) begin
      @(posedge CLK_I);
      #1;
      if (evs[w] && (w == 0 || w == 4 || !p)) k++;
      if (k >= 0) c++;
      p = evs[w];
    end
    chk(c - 1 == x);
  endtask : meas
  // Watchdog
  initial begin
    repeat (40000) @(posedge CLK_I);
    err_count++;
    close_out();
  end
  // Main sequence
  initial begin
    {RST_N_I, PSEL_I, PENABLE_I, PWRITE_I, host_run} = 5'h0;
    PADDR_I = 32'h0;
    PWDATA_I = 32'h0;
    PSTRB_I = 4'h0;
    void'($urandom(32'h75b9750e));
    repeat (6) @(posedge CLK_I);
    RST_N_I <= 1'h1;
    foreach (REGS[i]) rd(REGS[i], RSTV[i]);
    apb(1'h0, 10'h3fc, 16'h0, 1'h1);
    apb(1'h1, CC1 | 10'h1, 16'hffff, 1'h1);
    rd(CC1, 16'h0);
    wr(PM4, 16'h0100);
    meas(4, 1, 64);
    wr(CC1, 16'hc000);
    meas(4, 1, 16);
    rd(PM4, 16'h0100);
    wr(PM4, 16'h0);
    rd(CC1, 16'h4000);
    repeat (80) begin
      @(posedge CLK_I);
      #1 chk(SLOW_TICK_O === 1'h0);
    end
    wr(BCC, 16'h4000);
    for (int c = 0; c < 16; c++) begin
      wr(CC1, 16'(c << 4));
      meas(0, 2, BPER[c]);
    end
    wr(PIN, 16'h0001);
    settle();
    chk(AUX_CLK_OE_O === 1'h1);
    chk(AUX_CLK_O === 1'h1);
    for (int c = 1; c < 6; c++) begin
      wr(CC1, 16'(c));
      meas(1, 2, APER[c]);
    end
    wr(CC1, 16'h0006);
    repeat (8) @(posedge CLK_I);
    repeat (10) begin
      settle();
      chk(AUX_CLK_O === 1'h0);
    end
    wr(PIN, 16'h0);
    settle();
    chk(AUX_CLK_OE_O === 1'h0);
    wr(CC1, 16'h0020);
    len = 8 + $urandom_range(15, 0);
    wr(PB, 16'h0800 | 16'(len));
    meas(2, 1, 4 * len);
    chk(FRAME_CLK_OE_O === 1'h1);
    wr(PB, 16'(len));
    settle();
    chk(FRAME_CLK_OE_O === 1'h0);
    wr(CC2, 16'h8000);
    wr(REC, 16'h0808);
    settle();
    chk(REC_FRAME_ALT_OE_O === 1'h0);
    meas(2, 1, 32);
    wr(PIN, 16'h0002);
    meas(3, 1, 32);
    chk(REC_FRAME_ALT_OE_O === 1'h1);
    wr(BCC, 16'h0);
    settle();
    chk(BIT_CLK_OE_O === 1'h0);
    @(posedge CLK_I);
    host_run <= 1'h1;
    meas(0, 2, 12);
    meas(5, 1, 96);
    close_out();
  end
endmodule : tb
